// ===== design/fpz_pkg.sv
// constants shared by the fan duty and zone limit block
package fpz_pkg;

  localparam int FPZ_ZONES = 3;

  // host-visible zone limit registers
  localparam logic [7:0] FPZ_LIMIT_OFS [FPZ_ZONES] = '{8'h67, 8'h68, 8'h69};
  localparam logic [7:0] FPZ_LIMIT_RST = 8'h5a;
  localparam logic [7:0] FPZ_RDATA_UNMAPPED = 8'h00;

  localparam logic [7:0] FPZ_DUTY_OFF = 8'h00;
  localparam logic [7:0] FPZ_DUTY_FULL = 8'hff;
  // low band: 255 steps per period, so 8'hff gives a steady high
  localparam logic [7:0] FPZ_LO_STEPS = 8'hff;

  // high band step rate is the same for every frequency: f * levels
  localparam int FPZ_CLK_HZ = 250000000;
  localparam int FPZ_HI_STEP_HZ = 360000;
  localparam int FPZ_HI_STEP_CYC = FPZ_CLK_HZ / FPZ_HI_STEP_HZ;

  // nonzero duty levels per high band frequency code
  localparam logic [4:0] FPZ_HI_LEVELS [8] = '{5'h10, 5'h0f, 5'h0e, 5'h0e,
                                               5'h0d, 5'h0d, 5'h0c, 5'h0c};
  localparam logic [2:0] FPZ_HI_GROUP [8] = '{3'h0, 3'h1, 3'h2, 3'h2,
                                              3'h3, 3'h3, 3'h4, 3'h4};
  // first value of levels 2..n; 9'h100 is never reached
  localparam logic [8:0] FPZ_QSTEP [5][15] = '{
    '{9'h010, 9'h020, 9'h030, 9'h040, 9'h050, 9'h060, 9'h070, 9'h080,
      9'h090, 9'h0a0, 9'h0b0, 9'h0c0, 9'h0d0, 9'h0e0, 9'h0f0},
    '{9'h011, 9'h022, 9'h033, 9'h044, 9'h055, 9'h066, 9'h077, 9'h089,
      9'h09a, 9'h0ab, 9'h0bc, 9'h0cd, 9'h0de, 9'h0ef, 9'h100},
    '{9'h012, 9'h025, 9'h037, 9'h049, 9'h05b, 9'h06e, 9'h080, 9'h092,
      9'h0a5, 9'h0b7, 9'h0c9, 9'h0db, 9'h0ee, 9'h100, 9'h100},
    '{9'h014, 9'h027, 9'h03b, 9'h04f, 9'h062, 9'h076, 9'h08a, 9'h09e,
      9'h0b1, 9'h0c5, 9'h0d9, 9'h0ec, 9'h100, 9'h100, 9'h100},
    '{9'h015, 9'h02b, 9'h040, 9'h055, 9'h06b, 9'h080, 9'h095, 9'h0ab,
      9'h0c0, 9'h0d5, 9'h0eb, 9'h100, 9'h100, 9'h100, 9'h100}};

  // ramp width in twelfths of a degree keeps 2.5, 3.33, 6.67 exact
  localparam logic [9:0] FPZ_RANGE_X12 [16] = '{
    10'h018, 10'h01e, 10'h028, 10'h030, 10'h03c, 10'h050, 10'h060, 10'h078,
    10'h0a0, 10'h0c0, 10'h0f0, 10'h140, 10'h180, 10'h1e0, 10'h280, 10'h3c0};
  localparam logic [12:0] FPZ_DEG_X12 = 13'h00c;

endpackage : fpz_pkg

// ===== design/fpz_zone_if.sv
// per-zone signals between the block top and a zone duty engine
`timescale 1ns/10ps
interface fpz_zone_if;
  logic [7:0] temp;
  logic [7:0] limit;
  logic [7:0] min_duty;
  logic [3:0] ramp_sel;
  logic [3:0] hyst;
  logic off_min;
  logic [7:0] duty;
  logic active;
  modport ctrl (output temp, limit, min_duty, ramp_sel, hyst, off_min,
                input duty, active);
  modport zone (input temp, limit, min_duty, ramp_sel, hyst, off_min,
                output duty, active);
endinterface : fpz_zone_if

// ===== design/fpz_zone_duty.sv
// one zone: limit compare, ramp, below-limit choice and hysteresis
`timescale 1ns/10ps
module fpz_zone_duty
  import fpz_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  fpz_zone_if.zone zif
);

  typedef struct packed {
    logic [7:0] duty;
    logic active;
  } fpz_zone_s;

  fpz_zone_s st_ff;
  fpz_zone_s nxt_st;
  logic signed [8:0] diff;
  logic signed [8:0] hyst_neg;
  logic [9:0] span;
  logic [12:0] d12;
  logic [20:0] quo;

  assign diff = $signed({zif.temp[7], zif.temp}) -
                $signed({zif.limit[7], zif.limit});
  assign hyst_neg = -$signed({5'h00, zif.hyst});
  assign span = FPZ_RANGE_X12[zif.ramp_sel];
  assign d12 = 13'(diff[7:0]) * FPZ_DEG_X12;
  assign quo = (21'(FPZ_DUTY_FULL - zif.min_duty) * 21'(d12)) / 21'(span);

  always_comb begin
    nxt_st = st_ff;
    if (diff == 9'sh000) begin
      nxt_st.active = 1'b1;
      nxt_st.duty = zif.min_duty;
    end else if (diff > 9'sh000) begin
      nxt_st.active = 1'b1;
      if (d12 >= 13'(span)) begin
        nxt_st.duty = FPZ_DUTY_FULL;
      end else begin
        nxt_st.duty = zif.min_duty + quo[7:0];
      end
    end else if (st_ff.active && diff >= hyst_neg) begin
      nxt_st.duty = zif.min_duty;
    end else begin
      nxt_st.active = 1'b0;
      nxt_st.duty = zif.off_min ? zif.min_duty : FPZ_DUTY_OFF;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign zif.duty = st_ff.duty;
  assign zif.active = st_ff.active;

  chk_limit_min_duty: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    diff == 9'sh000 |=> st_ff.active && st_ff.duty == $past(zif.min_duty))
    else $error("duty at limit is not the minimum");
  chk_ramp_full: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    diff > 9'sh000 && d12 >= 13'(span) |=> st_ff.duty == FPZ_DUTY_FULL)
    else $error("duty not full beyond ramp span");
  chk_ramp_floor: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    diff > 9'sh000 |=> st_ff.duty >= $past(zif.min_duty))
    else $error("ramp duty fell below minimum");
  chk_below_off: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !st_ff.active && diff < 9'sh000 && !zif.off_min
    |=> st_ff.duty == FPZ_DUTY_OFF && !st_ff.active)
    else $error("fan not off below limit");
  chk_hyst_hold: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    st_ff.active && diff < 9'sh000 && diff >= hyst_neg
    |=> st_ff.active && st_ff.duty == $past(zif.min_duty))
    else $error("fan left minimum inside hysteresis");

endmodule : fpz_zone_duty

// ===== design/fpz_fan_ctrl.sv
// zone limit registers, duty quantiser and pwm outputs for three fans
//
// Behaviour
// - high band coarsens duty; 0 off, top full
// - three zone limits reset to 90 degrees
// - fan switches on when temperature equals limit
// - above limit duty rises along the ramp
// - lock bit makes zone limits read-only
// - writes to locked limits are discarded
// - before start, default limit drives fan logic
// - limits are signed bytes, one degree each
// - zone limits sit at 67h, 68h, 69h
// - band select enables high band quantisation
// - minimum at limit, linear to full, then full
// - below limit select gives zero or minimum
// - minimum held until limit minus hysteresis
`timescale 1ns/10ps
module fpz_fan_ctrl
  import fpz_pkg::*;
#(
  // prescale per low band frequency code, 255 steps per period
  parameter logic [16:0] LO_DIV [8] = '{17'h17e95, 17'h0fef8, 17'h0a580,
                                        17'h07f7c, 17'h0645b, 17'h05161,
                                        17'h03e64, 17'h028b0}
)(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic lock_bit,
  input wire logic start_bit,
  input wire logic pwm_band_select,
  input wire logic [2:0] pwm_freq_sel,
  input wire logic [2:0][7:0] zone_temp,
  input wire logic [2:0][7:0] min_duty,
  input wire logic [2:0][3:0] ramp_width_field,
  input wire logic [2:0][3:0] hyst_amount,
  input wire logic [2:0] off_min_sel,
  output logic [2:0] pwm_out
);

  typedef struct packed {
    logic [2:0][7:0] limit;
    logic [7:0] rdata;
    logic [16:0] div;
    logic [7:0] step;
    logic [2:0] pwm;
  } fpz_top_s;

  // f * levels is near 360 kHz for every high code, so one step time fits
  localparam logic [16:0] HI_DIV = 17'(FPZ_HI_STEP_CYC);

  fpz_top_s st_ff;
  fpz_top_s nxt_st;
  logic [2:0][7:0] zone_duty;
  logic [2:0][7:0] eff_limit;
  logic [16:0] div_top;
  logic [7:0] period;

  ////////////////////////////////////////////////////////////////////////
  // quantiser: count thresholds passed, zero stays zero

  function automatic logic [4:0] fpz_quant(input logic [7:0] duty,
                                           input logic [2:0] freq);
    logic [4:0] lvl;
    lvl = (duty != FPZ_DUTY_OFF) ? 5'h01 : 5'h00;
    for (int k = 0; k < 15; k++) begin
      if ({1'b0, duty} >= FPZ_QSTEP[FPZ_HI_GROUP[freq]][k]) begin
        lvl = lvl + 5'h01;
      end
    end
    return lvl;
  endfunction : fpz_quant

  ////////////////////////////////////////////////////////////////////////
  // zone engines

  generate
    for (genvar g = 0; g < FPZ_ZONES; g++) begin : g_zone
      fpz_zone_if zif();
      assign eff_limit[g] = start_bit ? st_ff.limit[g] : FPZ_LIMIT_RST;
      assign zif.limit = eff_limit[g];
      assign zif.temp = zone_temp[g];
      assign zif.min_duty = min_duty[g];
      assign zif.ramp_sel = ramp_width_field[g];
      assign zif.hyst = hyst_amount[g];
      assign zif.off_min = off_min_sel[g];
      assign zone_duty[g] = zif.duty;
      fpz_zone_duty u_zone (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .zif(zif.zone)
      );

      // the engine must report on once temperature meets its limit
      chk_zone_on_limit: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        zone_temp[g] == eff_limit[g] |=> zif.active)
        else $error("zone not active at its limit");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // next state

  assign div_top = pwm_band_select ? HI_DIV : LO_DIV[pwm_freq_sel];
  assign period = pwm_band_select ? {3'h0, FPZ_HI_LEVELS[pwm_freq_sel]}
                                  : FPZ_LO_STEPS;

  always_comb begin
    nxt_st = st_ff;
    // step wraps at once if a frequency change shortened the period
    if (st_ff.step >= period) begin
      nxt_st.step = 8'h00;
      nxt_st.div = 17'h00000;
    end else if (st_ff.div >= div_top - 17'h00001) begin
      nxt_st.div = 17'h00000;
      nxt_st.step = (st_ff.step + 8'h01 >= period) ? 8'h00
                                                   : st_ff.step + 8'h01;
    end else begin
      nxt_st.div = st_ff.div + 17'h00001;
    end
    for (int i = 0; i < FPZ_ZONES; i++) begin
      if (reg_wr && reg_addr == FPZ_LIMIT_OFS[i]) begin
        if (!lock_bit) begin
          nxt_st.limit[i] = reg_wdata;
        end
      end
      if (pwm_band_select) begin
        nxt_st.pwm[i] = {3'h0, fpz_quant(zone_duty[i], pwm_freq_sel)} >
                        st_ff.step;
      end else begin
        nxt_st.pwm[i] = zone_duty[i] > st_ff.step;
      end
    end
    // stored value reads back even before start
    if (reg_rd) begin
      nxt_st.rdata = FPZ_RDATA_UNMAPPED;
      for (int i = 0; i < FPZ_ZONES; i++) begin
        if (reg_addr == FPZ_LIMIT_OFS[i]) begin
          nxt_st.rdata = st_ff.limit[i];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '{limit: {FPZ_ZONES{FPZ_LIMIT_RST}}, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign pwm_out = st_ff.pwm;

  ////////////////////////////////////////////////////////////////////////
  // checks

  chk_locked_write: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    reg_wr && lock_bit |=> st_ff.limit == $past(st_ff.limit))
    else $error("locked limit register changed");
  chk_write_store: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    reg_wr && !lock_bit && reg_addr == 8'h68
    |=> st_ff.limit[1] == $past(reg_wdata))
    else $error("zone 2 limit write not stored");
  chk_start_default: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !start_bit |-> eff_limit == {FPZ_ZONES{FPZ_LIMIT_RST}})
    else $error("stored limit used before start");
  chk_hi_zero_off: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    pwm_band_select && zone_duty[0] == FPZ_DUTY_OFF |=> !pwm_out[0])
    else $error("zero duty drove fan in high band");
  chk_hi_full_on: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    pwm_band_select && zone_duty[0] >= 8'hf0 && st_ff.step < period
    |=> pwm_out[0])
    else $error("top band not at full duty");
  chk_read_back: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    reg_rd && reg_addr == 8'h67 |=> reg_rdata == $past(st_ff.limit[0]))
    else $error("zone 1 limit read back wrong");
  chk_read_unmapped: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    reg_rd && reg_addr != FPZ_LIMIT_OFS[0] && reg_addr != FPZ_LIMIT_OFS[1]
    && reg_addr != FPZ_LIMIT_OFS[2] |=> reg_rdata == FPZ_RDATA_UNMAPPED)
    else $error("unmapped read did not return zero");
  // a shortened period may leave one stale step, wrapped next cycle
  chk_step_bound: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    period == $past(period) |-> st_ff.step < period)
    else $error("pwm step beyond its period");
  chk_lo_full_on: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !pwm_band_select && zone_duty[0] == FPZ_DUTY_FULL && st_ff.step < period
    |=> pwm_out[0])
    else $error("full duty not steady high in low band");
  // code one: a duty of 10h is level one, high in step zero only
  chk_hi_level_one: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    pwm_band_select && pwm_freq_sel == 3'h1 && zone_duty[0] == 8'h10
    |=> pwm_out[0] == ($past(st_ff.step) == 8'h00))
    else $error("level one duty wrong at code one");

endmodule : fpz_fan_ctrl

// ===== tb/fpz_fan_model.sv
// fan model: counts the cycles its pwm input is high in a window
`timescale 1ns/10ps
module fpz_fan_model (
  input wire logic ref_clk,
  input wire logic pwm,
  input wire logic meas,
  output int high_cnt
);
  // a fan only sees the mean drive, so the window sum is what matters
  always_ff @(posedge ref_clk) begin
    if (!meas)
      high_cnt <= 0;
    else if (pwm)
      high_cnt <= high_cnt + 1;
  end
endmodule : fpz_fan_model

// ===== tb/fan_pwm_duty_and_zone_limit_bench.sv
// self-checking bench for the fan duty and zone limit block
`timescale 1ns/10ps
module fan_pwm_duty_and_zone_limit_bench;
  import fpz_pkg::*;
  localparam int hi_step = 694;
  // low band steps shortened to 4 cycles, so a period is 1020 cycles
  localparam int lo_per = 1020;
  logic ref_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
  logic lock_bit = 0, start_bit = 0, pwm_band_select = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [2:0] pwm_freq_sel = 3'h0, off_min_sel = 3'h0, pwm_out;
  logic [2:0][7:0] zone_temp = {3{8'h80}}, min_duty = {3{8'h80}};
  logic [2:0][3:0] ramp_width_field = '0, hyst_amount = '0;
  logic meas = 0;
  int msel = 0, high_cnt, n_errors = 0, checks = 0, cycles = 0;
  int lv [8] = '{2, 1, 2, 0, 1, 2, 2, 12};
  int nl [8] = '{16, 15, 14, 14, 13, 13, 12, 12};
  logic [7:0] hv [8] = '{8'h10, 8'h10, 8'h12, 8'h00,
                         8'h13, 8'h14, 8'h15, 8'hff};

  always #2 ref_clk = ~ref_clk;

  fpz_fan_ctrl #(.LO_DIV('{default: 17'h00004})) fpz_fan_ctrl_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .lock_bit(lock_bit), .start_bit(start_bit),
    .pwm_band_select(pwm_band_select), .pwm_freq_sel(pwm_freq_sel),
    .zone_temp(zone_temp), .min_duty(min_duty),
    .ramp_width_field(ramp_width_field), .hyst_amount(hyst_amount),
    .off_min_sel(off_min_sel), .pwm_out(pwm_out));

  fpz_fan_model fpz_fan_model_inst (.ref_clk(ref_clk),
    .pwm(pwm_out[msel]), .meas(meas), .high_cnt(high_cnt));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", what, e, g);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk) #1;
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk) #1;
    reg_wr = 0;
  endtask : wr

  task automatic rd(input logic [7:0] a, e);
    @(posedge ref_clk) #1;
    reg_rd = 1;
    reg_addr = a;
    @(posedge ref_clk) #1;
    reg_rd = 0;
    check("reg_rdata", {24'h0, e}, {24'h0, reg_rdata});
  endtask : rd

  // settle the two-cycle fan path, then sum one full pwm period
  task automatic duty(input int z, n, e);
    msel = z;
    repeat (4) @(posedge ref_clk);
    #1 meas = 1;
    repeat (n) @(posedge ref_clk);
    #1 meas = 0;
    check("pwm high cycles", e, high_cnt);
  endtask : duty

  task automatic complete_run();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  // the full run needs about 90k cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 100000) begin
      n_errors++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge ref_clk);
    #1 reset_n = 1;
    for (int z = 0; z < 3; z++)
      rd(FPZ_LIMIT_OFS[z], FPZ_LIMIT_RST);
    rd(8'h6a, FPZ_RDATA_UNMAPPED);
    wr(8'h67, 8'h32);
    wr(8'h68, 8'hce);
    wr(8'h69, 8'h81);
    rd(8'h68, 8'hce);
    rd(8'h69, 8'h81);
    lock_bit = 1;
    wr(8'h67, 8'h11);
    rd(8'h67, 8'h32);
    lock_bit = 0;
    $display("test registers done");
    // stored limit 50 is ignored until start, default 90 applies
    zone_temp[0] = 8'h32;
    duty(0, lo_per, 0);
    start_bit = 1;
    duty(0, lo_per, 128 * 4);
    ramp_width_field[0] = 4'h6;
    zone_temp[0] = 8'h36;
    duty(0, lo_per, 191 * 4);
    zone_temp[0] = 8'h3a;
    duty(0, lo_per, lo_per);
    $display("test start and ramp done");
    hyst_amount[0] = 4'h2;
    zone_temp[0] = 8'h30;
    duty(0, lo_per, 128 * 4);
    zone_temp[0] = 8'h2f;
    duty(0, lo_per, 0);
    off_min_sel[0] = 1;
    duty(0, lo_per, 128 * 4);
    off_min_sel[0] = 0;
    zone_temp[0] = 8'h30;
    duty(0, lo_per, 0);
    $display("test below limit done");
    // signed compare: 50 is far above -50, -128 is below -127
    zone_temp[1] = 8'h32;
    duty(1, lo_per, lo_per);
    duty(2, lo_per, 0);
    zone_temp[0] = 8'h32;
    min_duty[0] = 8'h13;
    duty(0, lo_per, 19 * 4);
    $display("test signed limits done");
    pwm_band_select = 1;
    for (int c = 0; c < 8; c++) begin
      pwm_freq_sel = c[2:0];
      min_duty[0] = hv[c];
      duty(0, nl[c] * hi_step, lv[c] * hi_step);
    end
    $display("test high band done");
    complete_run();
  end
endmodule : fan_pwm_duty_and_zone_limit_bench
